// *** rtl/can_hk_defs.svh ***
`ifndef CAN_HK_DEFS_SVH
`define CAN_HK_DEFS_SVH

// Register word indices on the 16-bit bus
`define OFF_CTRL      8'h00
`define OFF_GSR       8'h01
`define OFF_IRR       8'h02
`define OFF_IRR_CLR   8'h03
`define OFF_IMR       8'h04
`define OFF_MAILBOX_IRQ_MASK     8'h05
`define OFF_REC       8'h06
`define OFF_TEC       8'h07
`define OFF_RXPEND    8'h08
`define MBX_BASE      8'h40

`define CTRL_SLEEP    0
`define CTRL_DMA0     2
`define CTRL_AUTOWAKE 7

`define GSR_BUSOFF    0
`define GSR_RXWARN    1
`define GSR_PASSIVE   2
`define GSR_RESET     3

`define IRQ_RESET     0
`define IRQ_MBX_RX    1
`define IRQ_REMOTE    2
`define IRQ_RXWARN    4
`define IRQ_PASSIVE   5
`define IRQ_BUSOFF    6
`define IRQ_RECOV     7
`define IRQ_TXDONE    8
`define IRQ_ACTIVITY  12

`define CTRL_RST      16'h0000
`define IRR_RST       16'h0001
`define IMR_RST       16'hFFFF
`define MAILBOX_IRQ_MASK_RST     16'hFFFF

`define REC_WARN      8'd96
`define REC_RECOV     8'd128
`define REC_PASSIVE   8'd128
`define REC_RELOAD    8'd127
`define REC_ERR_BIG   8'd8
`define TEC_PASSIVE   9'd128
`define TEC_BUSOFF    9'd256
`define TEC_ERR_INC   9'd8

`endif

// *** rtl/can_hk_pkg.sv ***
package can_hk_pkg;

  typedef struct packed {
    logic [15:0] rx_done;
    logic [15:0] rx_remote;
    logic [15:0] tx_done;
    logic [15:0] tx_cancel;
  } mbx_evt_t;

  typedef struct packed {
    logic rx_err;
    logic rx_err_big;
    logic rx_ok;
    logic tx_err;
    logic tx_ok;
    logic recessive11;
  } err_evt_t;

  typedef struct packed {
    logic [7:0] rec;
    logic [8:0] tec;
    logic       busoff;
    logic       warn;
    logic       recov;
  } err_st_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] flags;
    logic [15:0] interrupt_mask_register;
    logic [15:0] mailbox_irq_mask;
    logic [15:0] rx_pend;
    logic [2:0]  sync;
    logic        bus_lvl;
    logic        sleep;
    logic        done;
    logic        mb_sel;
    logic [15:0] rdata;
    logic        dma_req;
    logic        busoff_prev;
    logic        passive_prev;
  } hk_st_t;

endpackage

// *** rtl/mailbox_ram.sv ***
module mailbox_ram #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          sys_clk_i,
  input  wire logic          we_i,
  input  wire logic [1:0]    be_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [15:0]   wdata_i,
  output logic      [15:0]   rdata_o
);
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [15:0]            rdata;
  } ram_st_t;

  ram_st_t q;
  ram_st_t d;

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("mailbox_ram: DEPTH exceeds address range");
  end

  always_comb begin
    d = q;
    d.rdata = q.mem[addr_i];
    if (we_i && be_i[0]) d.mem[addr_i][7:0] = wdata_i[7:0];
    if (we_i && be_i[1]) d.mem[addr_i][15:8] = wdata_i[15:8];
  end

  // No reset: contents survive every controller reset
  always_ff @(posedge sys_clk_i) begin
    q <= d;
  end

  assign rdata_o = q.rdata;
endmodule

// *** rtl/err_counter.sv ***
module err_counter (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire can_hk_pkg::err_evt_t ev_i,
  output logic      [7:0]           rec_o,
  output logic      [8:0]           tec_o,
  output logic                      busoff_o,
  output logic                      passive_o,
  output logic                      warn_o,
  output logic                      recov_o
);
  import can_hk_pkg::*;
  `include "can_hk_defs.svh"

  err_st_t q;
  err_st_t d;

  function automatic logic [7:0] sat_add(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8] ? 8'hFF : s[7:0];
  endfunction

  always_comb begin
    d = q;
    d.warn = 1'b0;
    d.recov = 1'b0;
    if (q.busoff) begin
      // Receive counter reused for runs of 11 recessive bits
      if (ev_i.recessive11) begin
        d.rec = sat_add(q.rec, 8'd1);
        if (d.rec == `REC_WARN) d.warn = 1'b1;
        if (d.rec == `REC_RECOV) begin
          d.recov = 1'b1;
          d.rec = 8'd0;
          d.tec = 9'd0;
          d.busoff = 1'b0;
        end
      end
    end else begin
      if (ev_i.rx_err_big) d.rec = sat_add(q.rec, `REC_ERR_BIG);
      else if (ev_i.rx_err) d.rec = sat_add(q.rec, 8'd1);
      else if (ev_i.rx_ok && q.rec > `REC_PASSIVE) d.rec = `REC_RELOAD;
      else if (ev_i.rx_ok && q.rec != 8'd0) d.rec = q.rec - 8'd1;
      if (ev_i.tx_err) d.tec = q.tec + `TEC_ERR_INC;
      else if (ev_i.tx_ok && q.tec != 9'd0) d.tec = q.tec - 9'd1;
      if (d.rec >= `REC_WARN && q.rec < `REC_WARN) d.warn = 1'b1;
      if (d.tec >= `TEC_BUSOFF) begin
        d.busoff = 1'b1;
        d.rec = 8'd0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) q <= '0;
    else q <= d;
  end

  assign rec_o = q.rec;
  assign tec_o = q.tec;
  assign busoff_o = q.busoff;
  assign passive_o = !q.busoff && (q.tec >= `TEC_PASSIVE ||
                                   q.rec >= `REC_PASSIVE);
  assign warn_o = q.warn;
  assign recov_o = q.recov;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_busoff_run_count: assert property (
    q.busoff && ev_i.recessive11 && q.rec < 8'd127
    |=> q.rec == $past(q.rec) + 8'd1)
    else $error("bus-off run not counted");

  a_rec_single_up: assert property (
    !q.busoff && ev_i.rx_err && !ev_i.rx_err_big && q.rec < 8'd200
    |=> q.rec == $past(q.rec) + 8'd1)
    else $error("receive error not counted");
endmodule

// *** rtl/can_hk_ctrl.sv ***
// The address map and register access over Avalon-MM are this design's own decisions.
module can_hk_ctrl #(
  parameter int MBX_WORDS = 4
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [1:0]           avs_byteenable_i,
  input  wire logic [15:0]          avs_writedata_i,
  output logic      [15:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  input  wire logic                 can_rx_i,
  input  wire logic                 bus_idle_i,
  input  wire can_hk_pkg::mbx_evt_t mbx_ev_i,
  input  wire can_hk_pkg::err_evt_t err_ev_i,
  input  wire logic                 dma_done_i,
  output logic                      dma_req_o,
  output logic                      sleep_o,
  output logic                      irq_o
);
  import can_hk_pkg::*;
  `include "can_hk_defs.svh"

  localparam int DEPTH = 16 * MBX_WORDS;
  localparam int AW = $clog2(DEPTH);

  if (MBX_WORDS != 1 && MBX_WORDS != 2 && MBX_WORDS != 4 &&
      MBX_WORDS != 8) begin : g_bad_words
    $error("can_hk_ctrl: MBX_WORDS must be 1, 2, 4 or 8");
  end

  hk_st_t      q;
  hk_st_t      d;
  logic        acc;
  logic        wr;
  logic        mb_hit;
  logic [7:0]  mb_off;
  logic [15:0] clr;
  logic [15:0] set;
  logic [15:0] pend_clr;
  logic [15:0] general_status_register;
  logic [15:0] rx_unmasked;
  logic        act;
  logic [15:0] ram_rdata;
  logic [7:0]  rec;
  logic [8:0]  tec;
  logic        busoff;
  logic        passive;
  logic        warn_p;
  logic        recov_p;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0]  be);
    merge = old;
    if (be[0]) merge[7:0] = wd[7:0];
    if (be[1]) merge[15:8] = wd[15:8];
  endfunction

  err_counter u_err (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ev_i      (err_ev_i),
    .rec_o     (rec),
    .tec_o     (tec),
    .busoff_o  (busoff),
    .passive_o (passive),
    .warn_o    (warn_p),
    .recov_o   (recov_p)
  );

  // Bus takes one wait cycle; the 16-bit data path rules out long words
  assign acc = (avs_read_i || avs_write_i) && !q.done;
  assign wr = acc && avs_write_i;
  assign mb_off = avs_address_i - `MBX_BASE;
  assign mb_hit = avs_address_i >= `MBX_BASE &&
                  {24'h0, mb_off} < DEPTH;

  mailbox_ram #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mbx (
    .sys_clk_i (sys_clk_i),
    .we_i      (wr && mb_hit),
    .be_i      (avs_byteenable_i),
    .addr_i    (mb_off[AW-1:0]),
    .wdata_i   (avs_writedata_i),
    .rdata_o   (ram_rdata)
  );

  // Reset-state bit mirrors sleep
  assign general_status_register = {12'h000, q.sleep, passive,
                rec >= `REC_WARN, busoff};

  // Mailbox 0 in DMA mode keeps its receptions away from the flag
  assign rx_unmasked = mbx_ev_i.rx_done & ~q.mailbox_irq_mask &
                       ~{15'h0000, q.ctrl[`CTRL_DMA0]};

  // Dominant level seen once the last two stages agree
  assign act = q.sleep && q.bus_lvl && !q.sync[2] &&
               (q.sync[1] == q.sync[2]);

  always_comb begin
    d = q;
    clr = 16'h0000;
    pend_clr = 16'h0000;
    set = 16'h0000;
    d.sync = {q.sync[1:0], can_rx_i};
    if (q.sync[1] == q.sync[2]) d.bus_lvl = q.sync[2];
    d.done = acc;
    d.busoff_prev = busoff;
    d.passive_prev = passive;

    set[`IRQ_MBX_RX] = |rx_unmasked;
    set[`IRQ_REMOTE] = |(mbx_ev_i.rx_remote & ~q.mailbox_irq_mask);
    set[`IRQ_TXDONE] = |((mbx_ev_i.tx_done | mbx_ev_i.tx_cancel) &
                         ~q.mailbox_irq_mask);
    set[`IRQ_RXWARN] = warn_p;
    set[`IRQ_RECOV] = recov_p;
    set[`IRQ_BUSOFF] = busoff && !q.busoff_prev;
    set[`IRQ_PASSIVE] = passive && !q.passive_prev;
    set[`IRQ_ACTIVITY] = act;

    if (wr) begin
      unique case (avs_address_i)
        `OFF_CTRL:
          d.ctrl = merge(q.ctrl, avs_writedata_i, avs_byteenable_i);
        `OFF_IRR_CLR:
          clr = merge(16'h0000, avs_writedata_i, avs_byteenable_i);
        `OFF_IMR:
          d.interrupt_mask_register = merge(q.interrupt_mask_register, avs_writedata_i, avs_byteenable_i);
        `OFF_MAILBOX_IRQ_MASK:
          d.mailbox_irq_mask = merge(q.mailbox_irq_mask, avs_writedata_i, avs_byteenable_i);
        `OFF_RXPEND:
          pend_clr = merge(16'h0000, avs_writedata_i, avs_byteenable_i);
        default: ;
      endcase
    end

    // Set beats a clear arriving in the same cycle
    d.flags = (q.flags & ~clr) | set;

    // Completed DMA acknowledges mailbox 0 on its own
    if (dma_done_i) pend_clr[0] = 1'b1;
    d.rx_pend = (q.rx_pend & ~pend_clr) | mbx_ev_i.rx_done;

    if (dma_done_i) d.dma_req = 1'b0;
    if (q.ctrl[`CTRL_DMA0] && mbx_ev_i.rx_done[0]) d.dma_req = 1'b1;

    // Sleep waits for an idle bus before it is taken
    if (!d.ctrl[`CTRL_SLEEP]) d.sleep = 1'b0;
    else if (bus_idle_i) d.sleep = 1'b1;
    if (act && q.ctrl[`CTRL_AUTOWAKE]) begin
      d.ctrl[`CTRL_SLEEP] = 1'b0;
      d.sleep = 1'b0;
    end

    if (acc) begin
      d.mb_sel = mb_hit;
      unique case (avs_address_i)
        `OFF_CTRL:    d.rdata = q.ctrl;
        `OFF_GSR:     d.rdata = general_status_register;
        `OFF_IRR:     d.rdata = q.flags;
        `OFF_IMR:     d.rdata = q.interrupt_mask_register;
        `OFF_MAILBOX_IRQ_MASK:   d.rdata = q.mailbox_irq_mask;
        `OFF_REC:     d.rdata = {8'h00, rec};
        `OFF_TEC:     d.rdata = {7'h00, tec};
        `OFF_RXPEND:  d.rdata = q.rx_pend;
        default:      d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= `CTRL_RST;
      q.flags <= `IRR_RST;
      q.interrupt_mask_register <= `IMR_RST;
      q.mailbox_irq_mask <= `MAILBOX_IRQ_MASK_RST;
      q.bus_lvl <= 1'b1;
      q.sync <= 3'h7;
    end else begin
      q <= d;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !q.done;
  assign avs_readdata_o = q.mb_sel ? ram_rdata : q.rdata;
  assign dma_req_o = q.dma_req;
  assign sleep_o = q.sleep;
  // Reset event bypasses the mask
  assign irq_o = q.flags[`IRQ_RESET] || |(q.flags & ~q.interrupt_mask_register);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_dma0_rx;
    q.ctrl[`CTRL_DMA0] && mbx_ev_i.rx_done == 16'h0001 &&
    !q.flags[`IRQ_MBX_RX];
  endsequence

  sequence s_sleep_act;
    q.sleep && act;
  endsequence

  sequence s_busoff_run(logic [7:0] at);
    busoff && rec == at && err_ev_i.recessive11;
  endsequence

  a_reset_event: assert property (
    @(posedge sys_clk_i) disable iff (1'b0)
    $fell(rst_i) |-> q.flags[`IRQ_RESET] && irq_o)
    else $error("reset event flag not set after reset");

  a_regs_reset: assert property (
    @(posedge sys_clk_i) disable iff (1'b0)
    $fell(rst_i) |-> q.interrupt_mask_register == `IMR_RST && q.ctrl == `CTRL_RST &&
                     q.mailbox_irq_mask == `MAILBOX_IRQ_MASK_RST)
    else $error("register not at initial value after reset");

  a_reset_unmasked: assert property (
    q.flags[`IRQ_RESET] && q.interrupt_mask_register[`IRQ_RESET] |-> irq_o)
    else $error("reset event flag masked");

  a_sleep_status: assert property (
    q.sleep |-> general_status_register[`GSR_RESET])
    else $error("reset-state bit clear in sleep");

  a_bus_activity: assert property (
    s_sleep_act |=> q.flags[`IRQ_ACTIVITY])
    else $error("bus activity in sleep not flagged");

  a_activity_irq: assert property (
    q.flags[`IRQ_ACTIVITY] && !q.interrupt_mask_register[`IRQ_ACTIVITY] |-> irq_o)
    else $error("unmasked activity flag gives no interrupt");

  a_dma_no_irq: assert property (
    s_dma0_rx |=> !q.flags[`IRQ_MBX_RX] && dma_req_o)
    else $error("DMA reception raised receive flag");

  a_mbx_masked: assert property (
    !q.flags[`IRQ_TXDONE] &&
    ((mbx_ev_i.tx_done | mbx_ev_i.tx_cancel) & ~q.mailbox_irq_mask) == 16'h0000
    |=> !q.flags[`IRQ_TXDONE])
    else $error("masked mailbox set completion flag");

  a_busoff_warn: assert property (
    s_busoff_run(8'd95) |-> ##2 q.flags[`IRQ_RXWARN] &&
                              general_status_register[`GSR_RXWARN])
    else $error("warning not raised at 96 in bus-off");

  a_busoff_recov: assert property (
    s_busoff_run(8'd127) |-> ##2 q.flags[`IRQ_RECOV] && !busoff)
    else $error("recovery flag not raised at 128");

  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
    else $error("bus access not answered within one wait");
endmodule

// *** bench/can_bus_model.sv ***
module can_bus_model (
  input  wire logic       sys_clk_i,
  input  wire logic       go_i,
  input  wire logic [3:0] len_i,
  output logic            rx_o,
  output logic            idle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;

  // Dominant burst of len cycles, recessive otherwise
  always_ff @(posedge sys_clk_i) begin
    if (go_i) begin
      cnt_q <= len_i;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // Pin taken as already routed to the controller
  assign rx_o   = (cnt_q == 4'h0);
  assign idle_o = (cnt_q == 4'h0);
endmodule

// *** bench/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import can_hk_pkg::*;
  `include "can_hk_defs.svh"

  logic        clk = 1'b0;
  logic        rst;
  logic [7:0]  adr;
  logic        rd;
  logic        wr;
  logic [1:0]  be;
  logic [15:0] wd;
  logic [15:0] rdat;
  logic        wreq;
  logic        crx;
  logic        idle;
  mbx_evt_t    mev;
  err_evt_t    eev;
  logic        dmad;
  logic        dmar;
  logic        slp;
  logic        irq;
  logic        go;
  logic [3:0]  len;
  logic [15:0] r;
  logic [15:0] mbq[$];
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          rec_m;
  int          m;

  always #4 clk = ~clk;

  can_hk_ctrl #(.MBX_WORDS(4)) dut (
    .sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .can_rx_i(crx),
    .bus_idle_i(idle), .mbx_ev_i(mev), .err_ev_i(eev),
    .dma_done_i(dmad), .dma_req_o(dmar), .sleep_o(slp), .irq_o(irq));

  can_bus_model bus (
    .sys_clk_i(clk), .go_i(go), .len_i(len), .rx_o(crx), .idle_o(idle));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until the rising edge that sees waitrequest low
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [1:0] b, input logic [15:0] d);
    @(posedge clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    be  <= b;
    wd  <= d;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrt(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, a, 2'b11, d);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [15:0] k,
                     input logic [15:0] e);
    acc(1'b0, a, 2'b11, 16'h0000);
    chk(r & k, e);
  endtask

  task automatic pm(input mbx_evt_t x, input err_evt_t y);
    @(posedge clk);
    mev <= x;
    eev <= y;
    @(posedge clk);
    mev <= '0;
    eev <= '0;
    @(negedge clk);
  endtask

  task automatic ee(input int b);
    pm('0, err_evt_t'(6'(1 << b)));
  endtask

  task automatic do_rst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic conclude();
    $display("counts: %0d compared, %0d bad", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 8'h00; be = 2'b11;
    wd = 16'h0000; mev = '0; eev = '0; dmad = 1'b0; go = 1'b0;
    len = 4'h0;
    void'($urandom(32'h35A44D6F));
    do_rst();
    rdm(`OFF_CTRL, 16'hFFFF, `CTRL_RST);
    rdm(`OFF_IRR, 16'hFFFF, `IRR_RST);
    rdm(`OFF_IMR, 16'hFFFF, `IMR_RST);
    rdm(`OFF_MAILBOX_IRQ_MASK, 16'hFFFF, `MAILBOX_IRQ_MASK_RST);
    chk({15'h0000, irq}, 16'h0001);
    rdm(8'h20, 16'hFFFF, 16'h0000);
    wrt(`OFF_IRR_CLR, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    $display("test reset_values done");
    for (int k = 0; k < 4; k++) begin
      mbq.push_back(16'($urandom));
      wrt(`MBX_BASE + 8'(k), mbq[k]);
    end
    acc(1'b1, `OFF_IMR, 2'b01, 16'h1234);
    acc(1'b1, `OFF_IMR, 2'b10, 16'hAB00);
    rdm(`OFF_IMR, 16'hFFFF, 16'hAB34);
    do_rst();
    for (int k = 0; k < 4; k++) begin
      rdm(`MBX_BASE + 8'(k), 16'hFFFF, mbq[k]);
    end
    rdm(`OFF_IMR, 16'hFFFF, `IMR_RST);
    rdm(`OFF_IRR, 16'hFFFF, `IRR_RST);
    wrt(`OFF_IRR_CLR, 16'h0001);
    wrt(`OFF_IMR, 16'h0000);
    $display("test mailbox_keep done");
    // Kinds: rx done, remote, tx done, tx cancel
    for (int kd = 0; kd < 4; kd++) begin
      m = $urandom_range(1, 15);
      pm(mbx_evt_t'(64'h1 << (m + 16 * (3 - kd))), '0);
      rdm(`OFF_IRR, 16'hFFFF, 16'h0000);
      wrt(`OFF_MAILBOX_IRQ_MASK, ~(16'h0001 << m));
      pm(mbx_evt_t'(64'h1 << (m + 16 * (3 - kd))), '0);
      rdm(`OFF_IRR, 16'hFFFF, (kd < 2) ? 16'(2 << kd) : 16'h0100);
      chk({15'h0000, irq}, 16'h0001);
      wrt(`OFF_IRR_CLR, 16'hFFFF);
      wrt(`OFF_MAILBOX_IRQ_MASK, 16'hFFFF);
      wrt(`OFF_RXPEND, 16'hFFFF);
    end
    $display("test mailbox_mask done");
    wrt(`OFF_CTRL, 16'h0004);
    wrt(`OFF_MAILBOX_IRQ_MASK, 16'hFFFE);
    pm(mbx_evt_t'(64'h1 << 48), '0);
    chk({15'h0000, dmar}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    rdm(`OFF_IRR, 16'hFFFF, 16'h0000);
    @(posedge clk);
    dmad <= 1'b1;
    @(posedge clk);
    dmad <= 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0000, dmar}, 16'h0000);
    rdm(`OFF_RXPEND, 16'hFFFF, 16'h0000);
    wrt(`OFF_CTRL, 16'h0000);
    wrt(`OFF_MAILBOX_IRQ_MASK, 16'hFFFF);
    $display("test dma done");
    wrt(`OFF_IMR, 16'hEFFF);
    wrt(`OFF_CTRL, 16'h0001);
    repeat (3) @(negedge clk);
    chk({15'h0000, slp}, 16'h0001);
    rdm(`OFF_GSR, 16'h0008, 16'h0008);
    chk({15'h0000, irq}, 16'h0000);
    @(posedge clk);
    go  <= 1'b1;
    len <= 4'h6;
    @(posedge clk);
    go <= 1'b0;
    repeat (14) @(negedge clk);
    chk({15'h0000, slp}, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    rdm(`OFF_IRR, 16'hFFFF, 16'h1000);
    wrt(`OFF_IRR_CLR, 16'h1000);
    chk({15'h0000, irq}, 16'h0000);
    wrt(`OFF_IMR, 16'hFFFF);
    wrt(`OFF_CTRL, 16'h0000);
    repeat (3) @(negedge clk);
    chk({15'h0000, slp}, 16'h0000);
    rdm(`OFF_GSR, 16'h0008, 16'h0000);
    wrt(`OFF_CTRL, 16'h0081);
    repeat (3) @(negedge clk);
    chk({15'h0000, slp}, 16'h0001);
    @(posedge clk);
    go  <= 1'b1;
    len <= 4'h6;
    @(posedge clk);
    go <= 1'b0;
    repeat (14) @(negedge clk);
    chk({15'h0000, slp}, 16'h0000);
    rdm(`OFF_IRR, 16'h1000, 16'h1000);
    rdm(`OFF_CTRL, 16'hFFFF, 16'h0080);
    wrt(`OFF_IRR_CLR, 16'h1000);
    wrt(`OFF_CTRL, 16'h0000);
    $display("test sleep done");
    rec_m = $urandom_range(1, 20);
    repeat (rec_m) ee(5);
    ee(4);
    rec_m += 8;
    rdm(`OFF_REC, 16'hFFFF, 16'(rec_m));
    repeat (rec_m) ee(3);
    rdm(`OFF_REC, 16'hFFFF, 16'h0000);
    repeat (3) ee(2);
    ee(1);
    rdm(`OFF_TEC, 16'hFFFF, 16'd23);
    $display("test counters done");
    repeat (30) ee(2);
    rdm(`OFF_GSR, 16'h0001, 16'h0001);
    wrt(`OFF_IRR_CLR, 16'hFFFF);
    repeat (95) ee(0);
    repeat (3) @(negedge clk);
    rdm(`OFF_REC, 16'hFFFF, 16'd95);
    rdm(`OFF_IRR, 16'h0010, 16'h0000);
    ee(0);
    repeat (3) @(negedge clk);
    rdm(`OFF_IRR, 16'h0010, 16'h0010);
    rdm(`OFF_GSR, 16'h0002, 16'h0002);
    repeat (31) ee(0);
    repeat (3) @(negedge clk);
    rdm(`OFF_IRR, 16'h0080, 16'h0000);
    ee(0);
    repeat (3) @(negedge clk);
    rdm(`OFF_IRR, 16'h0080, 16'h0080);
    rdm(`OFF_REC, 16'hFFFF, 16'h0000);
    rdm(`OFF_GSR, 16'h0001, 16'h0000);
    $display("test busoff done");
    conclude();
  end
endmodule
